// *** hw/aair_pkg.sv ***
// constants, field layouts and types of the ability and identifier register block
// Functional notes
// - identifier bits 15:10 return the low six maker code bits, fixed, writes ignored
// - identifier bits 9:4 return the six-bit model number, msb at bit 9
// - identifier bits 3:0 return the revision, msb at bit 3, bumped per major change
// - advertisement register contents are sent to the partner as local abilities
// - advertisement bit 15 is read-write next page request, reset 0
// - advertisement bits 14 and 12 read 0, writes to them have no effect
// - advertisement bit 13 is read-write local remote fault flag, reset 0
// - advertisement bits 11 and 10 are read-write asymmetric and symmetric pause, reset 0
// - resolved pause outcome goes to the O_PAUSE_RESOLVED output, not the advertisement
// - advertisement bit 9, four-pair capability, is read-only zero
// - advertisement bits 8 and 7 are read-write, read 0 in reset, then loaded from straps caught once settled after reset
// - advertisement bits 6 and 5 are read-write ten megabit ability flags
// - advertisement bits 4:0 are a read-write selector resetting to 00001
// - partner register loads received base page, replaced by next page after success
// - partner bit 15 shows partner next page request, read-only, reset 0
// - partner bit 14 follows the negotiation engine acknowledge from incoming bursts
// - partner bit 13 shows partner remote fault; bit 12 reads 0 until a next page replaces the base page
// - partner bits 11, 10, 9 show asymmetric pause, pause, four-pair, reset 0
// - partner bits 8 to 5 show speed abilities, bits 4:0 its selector
// - registers are read through a management read transaction
package aair_pkg;
	localparam logic [4:0] REG_ID_LOW = 5'h03;
	localparam logic [4:0] REG_ADVERT = 5'h04;
	localparam logic [4:0] REG_PARTNER = 5'h05;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [4:0] HDR_LAST = 5'h0b;
	localparam logic [4:0] TURN_LAST = 5'h01;
	localparam logic [4:0] DATA_LAST = 5'h0f;
	localparam logic [15:0] ADV_RESET = 16'h0061;
	localparam logic [15:0] ADV_WR_MASK = 16'hadff;
	localparam logic [15:0] LP_BASE_MASK = 16'hafff;
	localparam int ADV_FAST_FD_BIT = 8;
	localparam int ADV_FAST_HD_BIT = 7;
	localparam int LP_ACK_BIT = 14;
	localparam int ASYM_BIT = 11;
	localparam int SYM_BIT = 10;
	localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;
	localparam logic [1:0] PAUSE_NONE = 2'h0;

	typedef enum logic [2:0] {
		AAIR_IDLE = 3'b000,
		AAIR_START = 3'b001,
		AAIR_HEADER = 3'b010,
		AAIR_TURN = 3'b011,
		AAIR_DATA = 3'b100
	} aair_state_t;

	typedef struct packed {
		logic f1;
		logic f2;
		logic f3;
		logic lvl;
	} aair_sync_t;

	typedef struct packed {
		aair_state_t state;
		logic mdc_prev;
		logic [4:0] cnt;
		logic [15:0] sh;
		logic [11:0] hdr;
		logic is_read;
		logic addr_hit;
		logic [4:0] reg_addr;
		logic mdio_out;
		logic mdio_oe;
		logic [15:0] adv;
		logic [15:0] lp;
		logic [15:0] np_hold;
		logic np_pend;
		logic cmpl_prev;
		logic [1:0] pause_res;
		logic [2:0] init_cnt;
		logic init_done;
		logic [4:0] phy_addr;
	} aair_state_reg_t;
endpackage

// *** hw/aair_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module aair_pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_pins,
	output logic [WIDTH-1:0] o_level
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			aair_pkg::aair_sync_t s_reg;
			aair_pkg::aair_sync_t s_next;
			always_comb
			begin
				s_next.f1 = i_pins[g];
				s_next.f2 = s_reg.f1;
				s_next.f3 = s_reg.f2;
				// first stage never feeds the filter; only stages two and three are compared
				s_next.lvl = (s_reg.f2 == s_reg.f3) ? s_reg.f3 : s_reg.lvl;
			end
			always_ff @(posedge i_clk or negedge i_nrst)
			begin
				if (!i_nrst)
					s_reg <= {4{RESET_VAL[g]}};
				else
					s_reg <= s_next;
			end
			assign o_level[g] = s_reg.lvl;
		end
	endgenerate
endmodule // aair_pin_sync

// *** hw/aair_regs.sv ***
// management serial slave with identifier, advertisement and partner ability registers
`timescale 1ns/1ps
module aair_regs #(
	parameter logic [5:0] MAKER_CODE_LOW = 6'h2a, // arbitrary value
	parameter logic [5:0] MODEL_NUMBER = 6'h1c, // arbitrary value
	parameter logic [3:0] REVISION = 4'h3 // arbitrary value
) (
	input wire logic I_MCLK,
	input wire logic I_NRST,
	input wire logic I_MDC,
	input wire logic I_MDIO,
	output logic O_MDIO_OUT,
	output logic O_MDIO_OE,
	input wire logic [4:0] I_STRAP_PHY_ADDR,
	input wire logic I_STRAP_FAST_FD,
	input wire logic I_STRAP_FAST_HD,
	input wire logic I_AN_PAGE_STROBE,
	input wire logic I_AN_PAGE_IS_BASE,
	input wire logic [15:0] I_AN_PAGE,
	input wire logic I_AN_PARTNER_ACK,
	input wire logic I_AN_COMPLETE,
	output logic [15:0] O_ADVERT_WORD,
	output logic [1:0] O_PAUSE_RESOLVED
);
	localparam logic [15:0] ID_WORD = {MAKER_CODE_LOW, MODEL_NUMBER, REVISION};

	logic [8:0] pins_lvl;
	logic mdc_s;
	logic mdio_s;
	logic [4:0] phy_s;
	logic fd_s;
	logic hd_s;
	aair_pkg::aair_state_reg_t st_reg;
	aair_pkg::aair_state_reg_t st_next;
	logic mdc_rise;
	logic [11:0] hdr_full;
	logic [15:0] wdata;
	logic wr_commit;
	logic rd_load;
	logic base_load;
	logic np_replace;

	aair_pin_sync #(
		.WIDTH(9),
		.RESET_VAL(9'h080)
	) u_sync (
		.i_clk(I_MCLK),
		.i_nrst(I_NRST),
		.i_pins({I_MDC, I_MDIO, I_STRAP_PHY_ADDR, I_STRAP_FAST_FD, I_STRAP_FAST_HD}),
		.o_level(pins_lvl)
	);
	assign mdc_s = pins_lvl[8];
	assign mdio_s = pins_lvl[7];
	assign phy_s = pins_lvl[6:2];
	assign fd_s = pins_lvl[1];
	assign hd_s = pins_lvl[0];

	function automatic logic [15:0] read_word(input logic [4:0] addr, input logic [15:0] adv,
		input logic [15:0] lp);
		logic [15:0] w;
		w = 16'h0000;
		if (addr == aair_pkg::REG_ID_LOW)
			w = ID_WORD;
		else if (addr == aair_pkg::REG_ADVERT)
			w = adv;
		else if (addr == aair_pkg::REG_PARTNER)
			w = lp;
		return w;
	endfunction

	// local is advertised pair, remote is partner pair; bit 1 transmit pause, bit 0 receive pause
	function automatic logic [1:0] resolve_pause(input logic l_sym, input logic l_asym,
		input logic p_sym, input logic p_asym);
		logic [1:0] r;
		r = aair_pkg::PAUSE_NONE;
		if (l_sym && p_sym)
			r = 2'h3;
		else if (!l_sym && l_asym && p_sym && p_asym)
			r = 2'h2;
		else if (l_sym && l_asym && !p_sym && p_asym)
			r = 2'h1;
		return r;
	endfunction

	assign mdc_rise = mdc_s && !st_reg.mdc_prev;
	assign hdr_full = {st_reg.hdr[10:0], mdio_s};
	assign wdata = {st_reg.sh[14:0], mdio_s};
	assign wr_commit = mdc_rise && (st_reg.state == aair_pkg::AAIR_DATA) && !st_reg.is_read
		&& st_reg.addr_hit && (st_reg.cnt == aair_pkg::DATA_LAST);
	assign rd_load = mdc_rise && (st_reg.state == aair_pkg::AAIR_TURN) && st_reg.is_read
		&& st_reg.addr_hit && (st_reg.cnt == 5'h00);
	assign base_load = I_AN_PAGE_STROBE && I_AN_PAGE_IS_BASE;
	assign np_replace = I_AN_COMPLETE && !st_reg.cmpl_prev && st_reg.np_pend;

	always_comb
	begin
		st_next = st_reg;
		st_next.mdc_prev = mdc_s;
		st_next.cmpl_prev = I_AN_COMPLETE;
		// straps settle through the synchroniser before they are caught
		if (!st_reg.init_done)
		begin
			st_next.init_cnt = st_reg.init_cnt + 3'h1;
			if (st_reg.init_cnt == aair_pkg::STRAP_SETTLE_CYCLES)
			begin
				st_next.init_done = 1'b1;
				st_next.phy_addr = phy_s;
				st_next.adv[aair_pkg::ADV_FAST_FD_BIT] = fd_s;
				st_next.adv[aair_pkg::ADV_FAST_HD_BIT] = hd_s;
			end
		end
		else if (mdc_rise)
		begin
			case (st_reg.state)
				aair_pkg::AAIR_IDLE:
				begin
					// preamble length is not enforced, so suppressed preambles also work
					if (!mdio_s)
						st_next.state = aair_pkg::AAIR_START;
				end
				aair_pkg::AAIR_START:
				begin
					st_next.cnt = 5'h00;
					st_next.state = mdio_s ? aair_pkg::AAIR_HEADER : aair_pkg::AAIR_IDLE;
				end
				aair_pkg::AAIR_HEADER:
				begin
					st_next.hdr = hdr_full;
					st_next.cnt = st_reg.cnt + 5'h01;
					if (st_reg.cnt == aair_pkg::HDR_LAST)
					begin
						st_next.cnt = 5'h00;
						st_next.is_read = (hdr_full[11:10] == aair_pkg::OP_READ);
						st_next.addr_hit = (hdr_full[9:5] == st_reg.phy_addr);
						st_next.reg_addr = hdr_full[4:0];
						if ((hdr_full[11:10] == aair_pkg::OP_READ) || (hdr_full[11:10] == aair_pkg::OP_WRITE))
							st_next.state = aair_pkg::AAIR_TURN;
						else
							st_next.state = aair_pkg::AAIR_IDLE;
					end
				end
				aair_pkg::AAIR_TURN:
				begin
					st_next.cnt = st_reg.cnt + 5'h01;
					if (rd_load)
					begin
						st_next.mdio_oe = 1'b1;
						st_next.mdio_out = 1'b0;
						st_next.sh = read_word(st_reg.reg_addr, st_reg.adv, st_reg.lp);
					end
					if (st_reg.cnt == aair_pkg::TURN_LAST)
					begin
						st_next.cnt = 5'h00;
						st_next.state = aair_pkg::AAIR_DATA;
						st_next.mdio_out = st_reg.sh[15];
					end
				end
				aair_pkg::AAIR_DATA:
				begin
					st_next.cnt = st_reg.cnt + 5'h01;
					if (st_reg.is_read)
					begin
						st_next.sh = {st_reg.sh[14:0], 1'b0};
						st_next.mdio_out = st_reg.sh[14];
					end
					else
						st_next.sh = wdata;
					if (st_reg.cnt == aair_pkg::DATA_LAST)
					begin
						st_next.state = aair_pkg::AAIR_IDLE;
						st_next.mdio_oe = 1'b0;
						st_next.mdio_out = 1'b0;
						// only the writable advertisement bits take the word; all else is dropped
						if (wr_commit && (st_reg.reg_addr == aair_pkg::REG_ADVERT))
							st_next.adv = wdata & aair_pkg::ADV_WR_MASK;
					end
				end
				default:
				begin
					st_next.state = aair_pkg::AAIR_IDLE;
					st_next.mdio_oe = 1'b0;
				end
			endcase
		end
		// partner word: base page masked, next page held until success
		if (base_load)
			st_next.lp = I_AN_PAGE & aair_pkg::LP_BASE_MASK;
		else if (I_AN_PAGE_STROBE)
		begin
			st_next.np_hold = I_AN_PAGE;
			st_next.np_pend = 1'b1;
		end
		if (np_replace)
		begin
			st_next.lp = st_reg.np_hold;
			// a next page landing with completion stays pending, so the set wins
			st_next.np_pend = I_AN_PAGE_STROBE && !I_AN_PAGE_IS_BASE;
		end
		st_next.lp[aair_pkg::LP_ACK_BIT] = I_AN_PARTNER_ACK;
		// resolution is only meaningful once negotiation has finished
		if (I_AN_COMPLETE)
			st_next.pause_res = resolve_pause(st_reg.adv[aair_pkg::SYM_BIT], st_reg.adv[aair_pkg::ASYM_BIT],
				st_reg.lp[aair_pkg::SYM_BIT], st_reg.lp[aair_pkg::ASYM_BIT]);
		else
			st_next.pause_res = aair_pkg::PAUSE_NONE;
	end

	always_ff @(posedge I_MCLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			st_reg <= '0;
			st_reg.state <= aair_pkg::AAIR_IDLE;
			st_reg.adv <= aair_pkg::ADV_RESET;
		end
		else
			st_reg <= st_next;
	end

	assign O_MDIO_OUT = st_reg.mdio_out;
	assign O_MDIO_OE = st_reg.mdio_oe;
	assign O_ADVERT_WORD = st_reg.adv;
	assign O_PAUSE_RESOLVED = st_reg.pause_res;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_NRST);

	sequence read_turn_s;
		rd_load ##1 (st_reg.state == aair_pkg::AAIR_TURN);
	endsequence

	sequence write_last_s(logic [4:0] a);
		wr_commit && (st_reg.reg_addr == a);
	endsequence

	id_word_load_a: assert property (rd_load && (st_reg.reg_addr == aair_pkg::REG_ID_LOW) |=> st_reg.sh == ID_WORD)
		else $error("identifier word loaded with wrong value");
	advert_write_a: assert property (write_last_s(aair_pkg::REG_ADVERT) |=>
		O_ADVERT_WORD == ($past(wdata) & aair_pkg::ADV_WR_MASK))
		else $error("advertisement write not taken through mask");
	advert_fixed_a: assert property (O_ADVERT_WORD[14] == 1'b0 && O_ADVERT_WORD[12] == 1'b0
		&& O_ADVERT_WORD[9] == 1'b0)
		else $error("fixed advertisement bits not zero");
	ro_write_drop_a: assert property (wr_commit && (st_reg.reg_addr != aair_pkg::REG_ADVERT) |=>
		$stable(O_ADVERT_WORD))
		else $error("write to read-only register changed state");
	turn_drive_a: assert property (read_turn_s |-> O_MDIO_OE && !O_MDIO_OUT)
		else $error("turnaround zero not driven on read");
	oe_window_a: assert property (O_MDIO_OE |-> (st_reg.state == aair_pkg::AAIR_TURN)
		|| (st_reg.state == aair_pkg::AAIR_DATA))
		else $error("data line driven outside a read frame");
	partner_ack_a: assert property (##1 st_reg.lp[aair_pkg::LP_ACK_BIT] == $past(I_AN_PARTNER_ACK))
		else $error("partner acknowledge bit does not follow engine");
	base_page_a: assert property (base_load && !np_replace |=> st_reg.lp[12] == 1'b0
		&& st_reg.lp[15] == $past(I_AN_PAGE[15]) && st_reg.lp[11:0] == $past(I_AN_PAGE[11:0]))
		else $error("base page not loaded into partner word");
	next_page_a: assert property (np_replace |=> st_reg.lp[15] == $past(st_reg.np_hold[15])
		&& st_reg.lp[13:0] == $past(st_reg.np_hold[13:0])
		&& st_reg.lp[aair_pkg::LP_ACK_BIT] == $past(I_AN_PARTNER_ACK))
		else $error("next page not moved in on completion");
	pause_idle_a: assert property (!I_AN_COMPLETE |=> O_PAUSE_RESOLVED == aair_pkg::PAUSE_NONE)
		else $error("pause outcome shown before completion");
endmodule // aair_regs

// *** verification/aair_mdio_host.sv ***
// station management controller model: drives the management clock and data pin
`timescale 1ns/1ps
module aair_mdio_host #(
	parameter int HALF = 10
) (
	input wire logic i_clk,
	input wire logic i_mdio,
	output logic o_mdc,
	output logic o_mdio,
	output logic o_oe,
	output logic o_rd_valid,
	output logic [15:0] o_rd_data
);
	initial
	begin
		o_mdc = 1'b0;
		o_mdio = 1'b1;
		o_oe = 1'b0;
		o_rd_valid = 1'b0;
		o_rd_data = 16'h0000;
	end

	// one bit cell; the clock stands low between frames, data is held across the rise
	task automatic bit_cell(input logic drive, input logic val, output logic seen);
		@(posedge i_clk);
		#1;
		o_oe = drive;
		if (drive)
			o_mdio = val;
		repeat (HALF) @(posedge i_clk);
		seen = i_mdio;
		#1;
		o_mdc = 1'b1;
		repeat (HALF) @(posedge i_clk);
		#1;
		o_mdc = 1'b0;
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_a,
		input logic [15:0] wdata);
		logic [31:0] word;
		logic [15:0] rd;
		logic s;
		word = {2'b01, op, phy, reg_a, 2'b10, wdata};
		// short preamble only; the block does not ask for the full one
		for (int i = 0; i < 2; i++)
			bit_cell(1'b1, 1'b1, s);
		for (int i = 31; i >= 0; i--)
		begin
			// released from the turnaround on for reads; the pull-up holds the line
			bit_cell(!(op == aair_pkg::OP_READ && i < 18), word[i], s);
			if (i < 16)
				rd[i] = s;
		end
		@(posedge i_clk);
		#1;
		o_oe = 1'b0;
		if (op == aair_pkg::OP_READ)
		begin
			o_rd_data = rd;
			o_rd_valid = 1'b1;
			@(posedge i_clk);
			#1;
			o_rd_valid = 1'b0;
		end
	endtask
endmodule // aair_mdio_host

// *** verification/tb_aair_regs.sv ***
// self-checking bench for the ability and identifier register block
`timescale 1ns/1ps
module tb_aair_regs;
	logic I_MCLK, I_NRST, mdc, h_d, h_oe, d_out, d_oe, rv, strb, is_base, ack, cmpl, fd, hd;
	logic [4:0] phy;
	logic [15:0] rdat, page, adv, d, bp, np, advw;
	logic [1:0] pres;
	logic [15:0] exp_q[$];
	int error_cnt = 0;
	int checked = 0;
	int seed;
	wire mdio;
	// pull-up on the shared data line when nobody drives it
	assign mdio = d_oe ? d_out : (h_oe ? h_d : 1'b1);

	aair_regs u_aair_regs (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_MDC(mdc), .I_MDIO(mdio),
		.O_MDIO_OUT(d_out), .O_MDIO_OE(d_oe), .I_STRAP_PHY_ADDR(phy), .I_STRAP_FAST_FD(fd),
		.I_STRAP_FAST_HD(hd), .I_AN_PAGE_STROBE(strb), .I_AN_PAGE_IS_BASE(is_base), .I_AN_PAGE(page),
		.I_AN_PARTNER_ACK(ack), .I_AN_COMPLETE(cmpl), .O_ADVERT_WORD(advw), .O_PAUSE_RESOLVED(pres));
	aair_mdio_host u_aair_mdio_host (.i_clk(I_MCLK), .i_mdio(mdio), .o_mdc(mdc), .o_mdio(h_d),
		.o_oe(h_oe), .o_rd_valid(rv), .o_rd_data(rdat));

	initial
	begin
		I_MCLK = 1'b0;
		forever #5 I_MCLK = ~I_MCLK;
	end

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] e);
		checked++;
		if (seen !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, seen);
		end
	endtask

	task automatic print_verdict();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic rd(input logic [4:0] a, input logic [4:0] r, input logic [15:0] e);
		exp_q.push_back(e);
		u_aair_mdio_host.frame(aair_pkg::OP_READ, a, r, 16'h0000);
	endtask

	task automatic wr(input logic [4:0] r, input logic [15:0] v);
		u_aair_mdio_host.frame(aair_pkg::OP_WRITE, phy, r, v);
	endtask

	task automatic pg(input logic base, input logic [15:0] v);
		@(posedge I_MCLK);
		#1;
		strb = 1'b1;
		is_base = base;
		page = v;
		@(posedge I_MCLK);
		#1;
		strb = 1'b0;
	endtask

	// pause resolution: bit1 transmit, bit0 receive
	function automatic logic [1:0] pause_exp(input logic ls, input logic la, input logic ps, input logic pa);
		if (ls && ps)
			return 2'b11;
		if (!ls && la && ps && pa)
			return 2'b10;
		if (ls && la && !ps && pa)
			return 2'b01;
		return 2'b00;
	endfunction

	// read results are compared in arrival order
	always @(posedge I_MCLK)
		if (rv === 1'b1 && exp_q.size() > 0)
			check("mgmt_read", rdat, exp_q.pop_front());

	initial
	begin
		repeat (60000) @(posedge I_MCLK);
		error_cnt++;
		print_verdict();
	end

	initial
	begin
		seed = 32'he17a623b;
		I_NRST = 1'b0;
		strb = 1'b0;
		is_base = 1'b1;
		page = 16'h0000;
		ack = 1'b0;
		cmpl = 1'b0;
		phy = $random(seed);
		fd = $random(seed);
		hd = $random(seed);
		repeat (12) @(posedge I_MCLK);
		#1;
		check("advert_reset", advw, 16'h0061);
		I_NRST = 1'b1;
		repeat (20) @(posedge I_MCLK);
		adv = 16'h0061 | {7'h00, fd, hd, 7'h00};
		check("advert_strap", advw, adv);
		rd(phy, aair_pkg::REG_ADVERT, adv);
		rd(phy, aair_pkg::REG_ID_LOW, {6'h2a, 6'h1c, 4'h3});
		wr(aair_pkg::REG_ID_LOW, 16'h0000);
		rd(phy, aair_pkg::REG_ID_LOW, {6'h2a, 6'h1c, 4'h3});
		rd(phy + 5'h01, aair_pkg::REG_ID_LOW, 16'hffff);
		rd(phy, 5'h10, 16'h0000);
		rd(phy, aair_pkg::REG_PARTNER, 16'h0000);
		cmpl = 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			d = (k == 0) ? 16'hf3ff : $random(seed);
			d[11:10] = k[1:0];
			// restart after writing is the controller's duty, not modelled here
			wr(aair_pkg::REG_ADVERT, d);
			adv = d & 16'hadff;
			check("advert_word", advw, adv);
			check("advert_t4", {15'h0000, advw[9]}, 16'h0000);
			rd(phy, aair_pkg::REG_ADVERT, adv);
			ack = k[0];
			bp = $random(seed);
			pg(1'b1, bp);
			rd(phy, aair_pkg::REG_PARTNER, (bp & 16'hafff) | {1'b0, ack, 14'h0000});
			check("pause", {14'h0000, pres}, {14'h0000, pause_exp(adv[10], adv[11], bp[10], bp[11])});
			check("advert_kept", advw, adv);
		end
		cmpl = 1'b0;
		repeat (3) @(posedge I_MCLK);
		check("pause_idle", {14'h0000, pres}, 16'h0000);
		ack = 1'b1;
		np = $random(seed);
		pg(1'b0, np);
		rd(phy, aair_pkg::REG_PARTNER, (bp & 16'hafff) | 16'h4000);
		cmpl = 1'b1;
		wr(aair_pkg::REG_PARTNER, ~np);
		rd(phy, aair_pkg::REG_PARTNER, (np & 16'hbfff) | 16'h4000);
		check("reads_pending", 16'(exp_q.size()), 16'h0000);
		print_verdict();
	end
endmodule // tb_aair_regs
